// ==== hdl/cid_decoder.sv ====
// instruction decoder of a 64-bit wide cam, with array, registers and match scan
// assumes an avalon-mm master and one synchronous clock; chain pins are synchronous
// How it works
// - read_source_select sets persistent data-read source; reset picks comparand_reg.
// - memory-at-address source loads address_pointer, first access there, then steps.
// - write_dest_select sets persistent data-write target; reset picks comparand_reg.
// - masked writes change only destination bits whose mask bit is zero.
// - last segment written to comparand or mask starts compare; memory writes do not.
// - one_shot_register_select aims only the next command access at a register.
// - one-shot writes skip next_free_slot and both persistent selects; reads allowed.
// - reading persistent_read_source also shows device id on bits 15 to 4.
// - data_move_op copies 64 bits; fields pick mask, destination, source or validity.
// - moves with absolute address load the pointer; address moves step it afterwards.
// - moves between array and comparand may be masked, zero bits change only.
// - move into memory sets validity valid or leaves it, per op-code.
// - register self-move, including the no-operation code, changes nothing.
// - validity_set_op writes validity to target; absolute target loads, then steps pointer.
// - compare_op checks only entries of that validity, through selected mask.
// - compare of empty entries looks at validity only, data fully masked.
// - special codes switch foreground and background register sets.
// - segment_counter_rewind returns both segment counters to their start limits.
// - comparand shifts rotate one bit within the cam field width.
// - second_mask shifts slide, replicating the edge bit, within cam field.
// - force_full_op drives chain_full_flag low.
// - address flag set means the next command write is the absolute address.
// - page address writes and force_full_op act only with input low, own flag high.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_decoder #(
  parameter int          DEPTH  = 2048,
  parameter logic [11:0] DEV_ID = 12'h5A3
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire cid_pkg::cid_avs_req_t avs_req,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                chain_full_in_n,
  output logic                     chain_full_flag_n
);
  import cid_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int LASTI = DEPTH - 1;
  if (DEPTH < 2 || DEPTH > 2048 || (1 << AW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two up to 2048");
  end

  logic [63:0]    mem [DEPTH];
  logic [1:0]     val_mem [DEPTH];
  logic [63:0]    cr_reg, mr2_reg;
  logic [63:0]    mr1_reg [2];
  logic [15:0]    ctrl_reg [2];
  logic [15:0]    seg_reg [2];
  logic [AW-1:0]  ar_reg [2];
  logic [2:0]     ps_reg [2];
  logic [7:0]     pd_reg [2];
  logic           bank_reg;
  logic [15:0]    pa_reg, ds_reg;
  logic [1:0]     dseg_reg, sseg_reg;
  logic           tco_pend_reg;
  logic [2:0]     tco_sel_reg;
  logic [15:0]    pend_op_reg;
  cid_state_t     state_reg;
  logic           forced_reg, full_reg, match_reg;
  logic           start_reg, scan_reg;
  logic [1:0]     cond_reg;
  logic [AW-1:0]  idx_reg, hm_reg, nf_reg;
  logic [63:0]    smask_reg;
  logic           hit_reg, emp_reg;
  logic           avs_waitrequest_reg, chain_full_flag_n_reg;
  logic [31:0]    avs_readdata_reg;

  assign avs_waitrequest   = avs_waitrequest_reg;
  assign avs_readdata      = avs_readdata_reg;
  assign chain_full_flag_n = chain_full_flag_n_reg;

  logic [15:0]   ctrl_cur, seg_cur, wd, opw;
  logic [63:0]   mr1_cur, cr_r, cr_l, mr_r, mr_l, camf;
  logic [AW-1:0] ar_cur, eaddr;
  logic [2:0]    grp, dd, ss, ps_cur;
  logic [1:0]    mm;
  logic          go, gwr, grd, is_cmd, is_dat, exec, take_op, gate, dlast, slast;
  always_comb begin
    ctrl_cur = ctrl_reg[bank_reg];
    seg_cur  = seg_reg[bank_reg];
    mr1_cur  = mr1_reg[bank_reg];
    ar_cur   = ar_reg[bank_reg];
    ps_cur   = ps_reg[bank_reg];
    wd       = avs_req.writedata[15:0];
    is_cmd   = avs_req.address == `CID_OFF_CMD;
    is_dat   = avs_req.address == `CID_OFF_DATA;
    // a running scan stalls the bus so no access sees half-updated match state
    go       = (avs_req.read | avs_req.write) & avs_waitrequest_reg & ~scan_reg & ~start_reg;
    gwr      = go & avs_req.write;
    grd      = go & avs_req.read;
    opw      = (state_reg == CID_OPERAND) ? pend_op_reg : wd;
    eaddr    = (state_reg == CID_OPERAND) ? wd[AW-1:0] : ar_cur;
    exec     = gwr & is_cmd & ~tco_pend_reg & ((state_reg == CID_OPERAND) | ~wd[`CID_FBIT]);
    take_op  = gwr & is_cmd & ~tco_pend_reg & (state_reg == CID_IDLE) & wd[`CID_FBIT];
    grp      = opw[`CID_GRP_LO +: 3];
    mm       = opw[`CID_MM_LO +: 2];
    dd       = opw[`CID_D_LO +: 3];
    ss       = opw[2:0];
    gate     = ~chain_full_in_n & chain_full_flag_n_reg;
    dlast    = dseg_reg == seg_cur[`CID_SC_DST_END +: 2];
    slast    = sseg_reg == seg_cur[`CID_SC_SRC_END +: 2];
    camf     = ~64'h0 >> (16 * int'(ctrl_cur[`CID_CT_WID_LO +: 2]));
  end

  cid_shift_unit #(.W(64)) u_shift (
    .cr       (cr_reg),
    .mr       (mr2_reg),
    .wid      (ctrl_cur[`CID_CT_WID_LO +: 2]),
    .cr_right (cr_r),
    .cr_left  (cr_l),
    .mr_right (mr_r),
    .mr_left  (mr_l)
  );

  function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [1:0] m);
    case (m)
      2'h1:    step = AW'(a + 1);
      2'h2:    step = AW'(a - 1);
      default: step = a;
    endcase
  endfunction

  function automatic logic [63:0] pick(input logic [2:0] s, input logic [AW-1:0] a);
    case (s)
      `CID_R_CR:  pick = cr_reg;
      `CID_R_MR1: pick = mr1_cur;
      `CID_R_MR2: pick = mr2_reg;
      `CID_R_MAR: pick = mem[a];
      `CID_R_MHM: pick = mem[hm_reg];
      default:    pick = 64'h0;
    endcase
  endfunction

  // zero mask bits let data through
  function automatic logic [63:0] merge(input logic [63:0] o, input logic [63:0] n, input logic [1:0] k);
    case (k)
      2'h1:    merge = (o & mr1_cur) | (n & ~mr1_cur);
      2'h2:    merge = (o & mr2_reg) | (n & ~mr2_reg);
      default: merge = n;
    endcase
  endfunction

  function automatic logic [63:0] segput(input logic [63:0] o, input logic [1:0] s, input logic [15:0] d);
    logic [63:0] r;
    r = o;
    r[16 * s +: 16] = d;
    segput = r;
  endfunction

  logic [63:0]   dnew, mvsrc;
  logic [AW-1:0] dadr, madr;
  logic [1:0]    pmm;
  logic [2:0]    pdst;
  always_comb begin
    pdst  = pd_reg[bank_reg][5:3];
    pmm   = pd_reg[bank_reg][7:6];
    dadr  = (pdst == `CID_R_MHM) ? hm_reg : (pdst == `CID_R_MNF) ? nf_reg : ar_cur;
    dnew  = merge(pick(pdst, dadr), segput(pick(pdst, dadr), dseg_reg, wd), pmm);
    madr  = (dd == `CID_R_MHM) ? hm_reg : eaddr;
    mvsrc = (dd == `CID_R_MAR || dd == `CID_R_MHM) ? pick({1'b0, ss[1:0]}, eaddr) : pick(ss, eaddr);
    // data writes follow the persistent target; the bus word may be plain data
    if (pdst == `CID_R_MNF) dnew = merge(mem[nf_reg], segput(mem[nf_reg], dseg_reg, wd), pmm);
    if (dd == `CID_R_MNF) madr = nf_reg;
  end

  // registers, array and op-code execution
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_reg[i] <= `CID_CTRL_RST;
        seg_reg[i]  <= `CID_SEG_RST;
        ar_reg[i]   <= '0;
        mr1_reg[i]  <= 64'h0;
        ps_reg[i]   <= `CID_PS_RST;
        pd_reg[i]   <= `CID_PD_RST;
      end
      for (int i = 0; i < DEPTH; i++) val_mem[i] <= `CID_V_EMPTY;
      cr_reg     <= 64'h0;
      mr2_reg    <= 64'h0;
      bank_reg   <= 1'b0;
      pa_reg     <= 16'h0;
      ds_reg     <= 16'h0;
      forced_reg <= 1'b0;
      start_reg  <= 1'b0;
      cond_reg   <= `CID_V_VALID;
    end else if (ce) begin
      start_reg <= 1'b0;
      if (gwr & is_cmd & tco_pend_reg) begin
        case (tco_sel_reg)
          `CID_T_CT: ctrl_reg[bank_reg] <= wd;
          `CID_T_PA: if (gate) pa_reg <= wd;
          `CID_T_SC: seg_reg[bank_reg] <= wd;
          `CID_T_AR: ar_reg[bank_reg] <= wd[AW-1:0];
          `CID_T_DS: ds_reg <= wd;
          default: ;
        endcase
      end
      if (exec) begin
        case (grp)
          `CID_GRP_SPS: begin
            ps_reg[bank_reg] <= ss;
            if (ss == `CID_R_MAR) ar_reg[bank_reg] <= eaddr;
          end
          `CID_GRP_SPD: begin
            pd_reg[bank_reg] <= opw[7:0];
            if (dd == `CID_R_MAR) ar_reg[bank_reg] <= eaddr;
          end
          `CID_GRP_MOV: begin
            if (dd == `CID_R_MAR || dd == `CID_R_MHM) begin
              mem[madr] <= merge(mem[madr], mvsrc, mm);
              if (ss[2]) val_mem[madr] <= `CID_V_VALID;
              if (dd == `CID_R_MAR) ar_reg[bank_reg] <= step(eaddr, ctrl_cur[1:0]);
            end else if (dd != ss) begin
              case (dd)
                `CID_R_CR:  cr_reg <= merge(cr_reg, mvsrc, mm);
                `CID_R_MR1: mr1_reg[bank_reg] <= mvsrc;
                `CID_R_MR2: mr2_reg <= mvsrc;
                default: ;
              endcase
              if (ss == `CID_R_MAR) ar_reg[bank_reg] <= step(eaddr, ctrl_cur[1:0]);
            end
          end
          `CID_GRP_VBC: begin
            val_mem[madr] <= ss[1:0];
            if (dd == `CID_R_MAR) ar_reg[bank_reg] <= step(eaddr, ctrl_cur[1:0]);
          end
          `CID_GRP_CMP: begin
            start_reg <= 1'b1;
            cond_reg  <= ss[1:0];
          end
          `CID_GRP_SPC: begin
            case (opw[5:0])
              `CID_SP_FG:  bank_reg <= 1'b0;
              `CID_SP_BG:  bank_reg <= 1'b1;
              `CID_SP_SCR: cr_reg <= cr_r;
              `CID_SP_SCL: cr_reg <= cr_l;
              `CID_SP_SMR: mr2_reg <= mr_r;
              `CID_SP_SML: mr2_reg <= mr_l;
              default: ;
            endcase
          end
          `CID_GRP_SFF: if (gate) forced_reg <= 1'b1;
          default: ;
        endcase
      end
      if (gwr & is_dat) begin
        case (pdst)
          `CID_R_CR:  cr_reg <= dnew;
          `CID_R_MR1: mr1_reg[bank_reg] <= dnew;
          `CID_R_MR2: mr2_reg <= dnew;
          default: begin
            mem[dadr] <= dnew;
            if (dlast) val_mem[dadr] <= pd_reg[bank_reg][1:0];
          end
        endcase
        if (dlast && pdst == `CID_R_MAR) ar_reg[bank_reg] <= step(ar_cur, ctrl_cur[1:0]);
        if (dlast && pdst <= `CID_R_MR2) begin
          start_reg <= 1'b1;
          cond_reg  <= `CID_V_VALID;
        end
      end
      if (grd & is_dat & slast & ps_cur == `CID_R_MAR) ar_reg[bank_reg] <= step(ar_cur, ctrl_cur[1:0]);
    end
  end

  // command sequencing: operand wait and one-shot target
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= CID_IDLE;
      pend_op_reg  <= 16'h0;
      tco_pend_reg <= 1'b0;
      tco_sel_reg  <= 3'h0;
    end else if (ce) begin
      case (state_reg)
        CID_IDLE: if (take_op) begin
          state_reg   <= CID_OPERAND;
          pend_op_reg <= wd;
        end
        CID_OPERAND: if (exec) state_reg <= CID_IDLE;
        default: state_reg <= CID_IDLE;
      endcase
      if (go & is_cmd & tco_pend_reg) tco_pend_reg <= 1'b0;
      else if (exec && grp == `CID_GRP_TCO) begin
        tco_pend_reg <= 1'b1;
        tco_sel_reg  <= dd;
      end
    end
  end

  // segment counters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dseg_reg <= 2'h0;
      sseg_reg <= 2'h0;
    end else if (ce) begin
      if (exec && grp == `CID_GRP_SPC && opw[5:0] == `CID_SP_RSC) begin
        dseg_reg <= seg_cur[`CID_SC_DST_ST +: 2];
        sseg_reg <= seg_cur[`CID_SC_SRC_ST +: 2];
      end else if (gwr & is_cmd & tco_pend_reg) begin
        // new limits land on this same edge, so start from the written word
        if (tco_sel_reg == `CID_T_SC) begin
          dseg_reg <= wd[`CID_SC_DST_ST +: 2];
          sseg_reg <= wd[`CID_SC_SRC_ST +: 2];
        end
      end else begin
        if (gwr & is_dat) dseg_reg <= dlast ? seg_cur[`CID_SC_DST_ST +: 2] : 2'(dseg_reg + 1);
        if (grd & is_dat) sseg_reg <= slast ? seg_cur[`CID_SC_SRC_ST +: 2] : 2'(sseg_reg + 1);
      end
    end
  end

  // match scan, one entry per cycle, lowest index wins
  logic [63:0] scan_mask;
  logic        hit_now;
  always_comb begin
    case (ctrl_cur[`CID_CT_CMSK_LO +: 2])
      2'h1:    scan_mask = mr1_cur | ~camf;
      2'h2:    scan_mask = mr2_reg | ~camf;
      default: scan_mask = ~camf;
    endcase
    if (cond_reg == `CID_V_EMPTY) scan_mask = ~64'h0;
    hit_now = (val_mem[idx_reg] == cond_reg) && (((mem[idx_reg] ^ cr_reg) & ~smask_reg) == 64'h0);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_reg  <= 1'b0;
      idx_reg   <= '0;
      smask_reg <= 64'h0;
      hit_reg   <= 1'b0;
      emp_reg   <= 1'b0;
      hm_reg    <= '0;
      nf_reg    <= '0;
      match_reg <= 1'b0;
      full_reg  <= 1'b0;
    end else if (ce) begin
      if (start_reg) begin
        scan_reg  <= 1'b1;
        idx_reg   <= '0;
        smask_reg <= scan_mask;
        hit_reg   <= 1'b0;
        emp_reg   <= 1'b0;
      end else if (scan_reg) begin
        if (hit_now && !hit_reg) begin
          hit_reg <= 1'b1;
          hm_reg  <= idx_reg;
        end
        if (val_mem[idx_reg] == `CID_V_EMPTY && !emp_reg) begin
          emp_reg <= 1'b1;
          nf_reg  <= idx_reg;
        end
        idx_reg <= AW'(idx_reg + 1);
        if (int'(idx_reg) == LASTI) begin
          scan_reg  <= 1'b0;
          match_reg <= hit_reg | hit_now;
          full_reg  <= ~(emp_reg | (val_mem[idx_reg] == `CID_V_EMPTY));
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) chain_full_flag_n_reg <= 1'b1;
    else if (ce) chain_full_flag_n_reg <= ~(forced_reg | full_reg);
  end

  // bus answer: one cycle of waitrequest low per accepted access
  logic [15:0] stat, tco_val;
  logic [63:0] rd64;
  always_comb begin
    stat = 16'h0;
    stat[`CID_ST_MATCH] = match_reg;
    stat[`CID_ST_FULL]  = full_reg;
    stat[`CID_ST_BUSY]  = scan_reg;
    stat[`CID_ST_HM_LO +: AW] = hm_reg;
    case (tco_sel_reg)
      `CID_T_CT: tco_val = ctrl_cur;
      `CID_T_PA: tco_val = pa_reg;
      `CID_T_SC: tco_val = seg_cur;
      `CID_T_NF: tco_val = 16'(nf_reg);
      `CID_T_AR: tco_val = 16'(ar_cur);
      `CID_T_DS: tco_val = ds_reg;
      `CID_T_PS: tco_val = {DEV_ID, 1'b0, ps_cur};
      default:   tco_val = {8'h00, pd_reg[bank_reg]};
    endcase
    rd64 = pick(ps_cur, ar_cur);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest_reg <= 1'b1;
      avs_readdata_reg    <= 32'h0;
    end else if (ce) begin
      avs_waitrequest_reg <= ~go;
      if (grd) begin
        if (is_cmd) avs_readdata_reg <= {16'h0, tco_pend_reg ? tco_val : stat};
        else if (is_dat) avs_readdata_reg <= {16'h0, rd64[16 * sseg_reg +: 16]};
        else if (avs_req.address == `CID_OFF_STAT) avs_readdata_reg <= {16'h0, stat};
        else avs_readdata_reg <= 32'h0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);
  a_answer_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  a_auto_cmp: assert property (gwr && is_dat && dlast && pdst == `CID_R_CR |=> ##1 scan_reg)
    else $error("no compare after comparand write");
  a_no_mem_cmp: assert property (gwr && is_dat && pdst == `CID_R_MAR |=> !start_reg)
    else $error("compare after memory write");
  a_operand_wait: assert property (take_op |=> state_reg == CID_OPERAND)
    else $error("flagged op not waiting for address");
  a_addr_load: assert property (exec && state_reg == CID_OPERAND && grp == `CID_GRP_SPS
    && ss == `CID_R_MAR |=> ar_cur == $past(wd[AW-1:0])) else $error("address not loaded");
  a_tco_once: assert property (go && is_cmd && tco_pend_reg |=> !tco_pend_reg)
    else $error("one-shot target persists");
  a_dev_id: assert property (grd && is_cmd && tco_pend_reg && tco_sel_reg == `CID_T_PS
    |=> avs_readdata[15:4] == DEV_ID) else $error("device id missing");
  a_sff_set: assert property (exec && grp == `CID_GRP_SFF && gate |=> ##1 !chain_full_flag_n)
    else $error("full flag not forced");
  a_sff_gated: assert property (exec && grp == `CID_GRP_SFF && chain_full_in_n |=> $stable(forced_reg))
    else $error("force acted while chain input high");
  a_nop_still: assert property (exec && grp == `CID_GRP_MOV && dd == ss && dd <= `CID_R_MR2
    |=> $stable(cr_reg) && $stable(mr2_reg) && $stable(mr1_cur)) else $error("self-move changed state");
  a_scan_len: assert property (start_reg |=> scan_reg [*2]) else $error("scan ended early");
  c_compare: cover property (start_reg ##1 scan_reg ##[1:1000] !scan_reg);
  c_operand: cover property (take_op ##[1:20] exec);
  c_sff: cover property (exec && grp == `CID_GRP_SFF && gate);
endmodule

// ==== hdl/cid_shift_unit.sv ====
// one-bit shifts of comparand (rotate) and second mask (sliding) within cam field
// assumes cam field occupies the low bits, width code 0..3 = 64/48/32/16 bits
`timescale 1ns/1ps
module cid_shift_unit #(
  parameter int W = 64
) (
  input  wire logic [W-1:0] cr,
  input  wire logic [W-1:0] mr,
  input  wire logic [1:0]   wid,
  output logic [W-1:0]      cr_right,
  output logic [W-1:0]      cr_left,
  output logic [W-1:0]      mr_right,
  output logic [W-1:0]      mr_left
);
  logic [6:0] top;
  assign top = 7'(W - 1 - 16 * int'(wid));
  if (W != 64) begin : g_chk
    $error("cid_shift_unit serves only 64 bits");
  end
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic hi_in;
    logic lo_in;
    if (i == W - 1) begin : g_top
      assign hi_in = cr[i];
    end else begin : g_mid
      assign hi_in = cr[i+1];
    end
    if (i == 0) begin : g_bot
      assign lo_in = cr[0];
    end else begin : g_low
      assign lo_in = cr[i-1];
    end
    logic mhi;
    logic mlo;
    if (i == W - 1) begin : g_mtop
      assign mhi = mr[i];
    end else begin : g_mmid
      assign mhi = mr[i+1];
    end
    if (i == 0) begin : g_mbot
      assign mlo = mr[0];
    end else begin : g_mlow
      assign mlo = mr[i-1];
    end
    // bits above the cam field hold still
    assign cr_right[i] = (i > top) ? cr[i] : (i == top) ? cr[0] : hi_in;
    assign cr_left[i]  = (i > top) ? cr[i] : (i == 0) ? cr[top[5:0]] : lo_in;
    // sliding mask: top replicates downward, bit 0 replicates upward
    assign mr_right[i] = (i > top) ? mr[i] : (i == top) ? mr[i] : mhi;
    assign mr_left[i]  = (i > top) ? mr[i] : (i == 0) ? mr[0] : mlo;
  end
endmodule

// ==== shared/cid_defines.svh ====
// constants of the cam instruction decoder: offsets, fields, codes, resets
// assumes a 16-bit command/data word carried in the low half of a 32-bit bus
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_OFF_CMD     4'h0
`define CID_OFF_DATA    4'h4
`define CID_OFF_STAT    4'h8
`define CID_FBIT        11
`define CID_GRP_LO      8
`define CID_MM_LO       6
`define CID_D_LO        3
`define CID_GRP_SPS     3'h0
`define CID_GRP_SPD     3'h1
`define CID_GRP_TCO     3'h2
`define CID_GRP_MOV     3'h3
`define CID_GRP_VBC     3'h4
`define CID_GRP_CMP     3'h5
`define CID_GRP_SPC     3'h6
`define CID_GRP_SFF     3'h7
`define CID_R_CR        3'h0
`define CID_R_MR1       3'h1
`define CID_R_MR2       3'h2
`define CID_R_MAR       3'h4
`define CID_R_MHM       3'h5
`define CID_R_MNF       3'h6
`define CID_T_CT        3'h0
`define CID_T_PA        3'h1
`define CID_T_SC        3'h2
`define CID_T_NF        3'h3
`define CID_T_AR        3'h4
`define CID_T_DS        3'h5
`define CID_T_PS        3'h6
`define CID_T_PD        3'h7
`define CID_V_VALID     2'h0
`define CID_V_EMPTY     2'h1
`define CID_V_SKIP      2'h2
`define CID_V_RANDOM    2'h3
`define CID_SP_FG       6'h00
`define CID_SP_BG       6'h01
`define CID_SP_RSC      6'h02
`define CID_SP_SCR      6'h08
`define CID_SP_SCL      6'h09
`define CID_SP_SMR      6'h10
`define CID_SP_SML      6'h11
`define CID_CT_STEP_LO  0
`define CID_CT_WID_LO   2
`define CID_CT_CMSK_LO  4
`define CID_SC_DST_ST   0
`define CID_SC_DST_END  2
`define CID_SC_SRC_ST   4
`define CID_SC_SRC_END  6
`define CID_ST_MATCH    0
`define CID_ST_FULL     1
`define CID_ST_BUSY     2
`define CID_ST_HM_LO    5
`define CID_ID_LO       4
`define CID_CTRL_RST    16'h0000
`define CID_SEG_RST     16'h00CC
`define CID_PS_RST      3'h0
`define CID_PD_RST      8'h00
`endif

// ==== shared/cid_pkg.sv ====
// types shared by the cam instruction decoder files
// assumes cid_defines.svh for all numeric constants
package cid_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } cid_avs_req_t;
  typedef enum logic [1:0] {
    CID_IDLE,
    CID_OPERAND
  } cid_state_t;
endpackage

// ==== verif/cam_instruction_decoder_tb.sv ====
// self-checking bench of the cam instruction decoder
// assumes cid_host as bus master; reads are checked against a queue of notes
`timescale 1ns/1ps
module cam_instruction_decoder_tb;
  import cid_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  rst     = 1'b1;
  logic                  ce      = 1'b1;
  logic                  fin_n   = 1'b1;
  cid_avs_req_t          req;
  logic [31:0]           rdata;
  logic                  wreq;
  logic                  ff_n;
  logic [15:0]           q[$];
  logic [15:0]           e;
  logic [63:0]           v1, v2, m, cr;
  int                    error_cnt = 0;
  int                    n_checks  = 0;
  initial forever #25 clk_sys = ~clk_sys;
  // small depth keeps each compare scan short; id value is arbitrary
  cid_decoder #(.DEPTH(16), .DEV_ID(12'h3C7)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .chain_full_in_n(fin_n), .chain_full_flag_n(ff_n));
  cid_host u_host (.clk_sys(clk_sys), .avs_waitrequest(wreq), .avs_req(req));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    if (req.read === 1'b1 && wreq === 1'b0) begin
      e = q.pop_front();
      chk(rdata, {16'h0000, e});
    end
  end
  task automatic cmd(input logic [15:0] d);
    u_host.acc(1'b1, 4'h0, d);
  endtask
  task automatic w64(input logic [63:0] v);
    for (int i = 0; i < 4; i++) u_host.acc(1'b1, 4'h4, v[16*i+:16]);
  endtask
  task automatic r64(input logic [63:0] v);
    for (int i = 0; i < 4; i++) begin
      q.push_back(v[16*i+:16]);
      u_host.acc(1'b0, 4'h4, 16'h0000);
    end
  endtask
  task automatic rdc(input logic [15:0] v);
    q.push_back(v);
    u_host.acc(1'b0, 4'h0, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(46));
    v1 = {$urandom, $urandom};
    v2 = {$urandom, $urandom};
    m  = {$urandom, $urandom};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    w64(v1);
    r64(v1);
    cmd(16'h0108);
    w64(m);
    cmd(16'h0140);
    w64(v2);
    cr = (v1 & m) | (v2 & ~m);
    cmd(16'h0001);
    r64(m);
    cmd(16'h0000);
    r64(cr);
    cmd(16'h0608);
    cr = {cr[0], cr[63:1]};
    r64(cr);
    cmd(16'h0230);
    rdc({12'h3C7, 4'h0});
    // flagged op-code: the next command write carries the address
    cmd(16'h0924);
    cmd(16'h0003);
    w64(v2);
    cmd(16'h0804);
    cmd(16'h0003);
    r64(v2);
    cmd(16'h0220);
    cmd(16'h0005);
    cmd(16'h0220);
    rdc(16'h0005);
    // move comparand into memory at address 7, read it back through the pointer
    cmd(16'h0B20);
    cmd(16'h0007);
    r64(cr);
    cmd(16'h0314);
    cmd(16'h0002);
    r64(cr);
    cmd(16'h0300);
    cmd(16'h0000);
    r64(cr);
    // entry 7 made valid, so a valid compare hits there: match, index 7
    cmd(16'h0420);
    cmd(16'h0500);
    rdc(16'h00E1);
    cmd(16'h0501);
    rdc(16'h0001);
    q.push_back(cr[15:0]);
    u_host.acc(1'b0, 4'h4, 16'h0000);
    cmd(16'h0602);
    r64(cr);
    cmd(16'h0601);
    cmd(16'h0001);
    r64(64'h0);
    cmd(16'h0600);
    r64(cr);
    cmd(16'h0700);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, ff_n}, 32'h1);
    fin_n <= 1'b0;
    cmd(16'h0700);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, ff_n}, 32'h0);
    // mid-run reset: source back to comparand, forced flag cleared
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    r64(64'h0);
    chk({31'h0, ff_n}, 32'h1);
    @(posedge clk_sys);
    test_done();
  end
endmodule

// ==== verif/cid_host.sv ====
// host model: avalon-mm master issuing command and data cycles
// assumes the bench calls acc one transfer at a time
`timescale 1ns/1ps
module cid_host (
  input  wire logic             clk_sys,
  input  wire logic             avs_waitrequest,
  output cid_pkg::cid_avs_req_t avs_req
);
  import cid_pkg::*;
  initial avs_req = '0;
  // holds the request until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_req <= '{read: !w, write: w, address: a, writedata: {16'h0000, d}};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_req <= '0;
  endtask
endmodule
